// ===== cca_core.sv
`timescale 1ns/1ps
module cca_core #(
  parameter int FLOOR_INIT = cca_pkg::FLOOR_INIT_CYC,
  parameter int DEPTH = cca_pkg::FLOOR_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic receive_path_enable,
  input wire logic antenna_sel,
  input wire logic [6:0] adc_level,
  input wire logic [7:0] sat_percent,
  input wire logic [6:0] lock_window,
  input wire logic [6:0] drift_limit,
  input wire logic [6:0] rf_power,
  input wire logic pn_detect,
  input wire logic [7:0] peak_sidelobe,
  input wire logic psk_present,
  input wire logic demod_data_ready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic channel_busy,
  output logic [6:0] rx_gain,
  output logic lna_enable,
  output logic acquire,
  output logic tracking,
  output logic pn_search
);

  typedef enum logic [1:0] {CCA_IDLE, CCA_SEARCH, CCA_ACQ, CCA_TRACK} cca_phase_t;

  typedef struct packed {
    logic [31:0] func;
    logic [31:0] pol;
    logic [31:0] sample;
    logic [31:0] thresh;
    logic [31:0] squelch;
    logic [31:0] qual;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [6:0] gain;
    logic lna_on;
    logic locked;
    logic [6:0] lock_level;
    logic seen_unlock;
    logic sense;
    logic quality;
    logic sq_prev;
    logic [15:0] dwell_cnt;
    logic locked_dwell;
    cca_phase_t phase;
    logic [6:0] floor0;
    logic [6:0] floor1;
    logic [6:0] run_min;
    logic [8:0] fill_cnt;
    logic [15:0] init_cnt;
    logic floor_valid;
    logic [7:0] sym_cnt;
    logic busy_smp;
    logic busy_out;
  } cca_state_t;

  cca_state_t s_q;
  cca_state_t s_d;
  logic [6:0] floor_mem [DEPTH];
  logic [7:0] mem_wp_q;
  logic [6:0] strength;
  logic [6:0] cur_floor;
  logic [7:0] ed_limit;
  logic ed_flag;
  logic busy_raw;
  logic [1:0] fsel;

  ////////////////////////////////////////////////////////////////////
  // Strength and energy detect
  // Strength is how far gain came down, plus the LNA 30 dB when off
  always_comb begin
    strength = 7'(cca_pkg::GAIN_MAX - s_q.gain);
    if (!s_q.lna_on) begin
      strength = 7'(strength + 7'(cca_pkg::LNA_DB));
    end
    cur_floor = antenna_sel ? s_q.floor1 : s_q.floor0;
    if (s_q.thresh[cca_pkg::THR_MODE_BIT]) begin
      ed_limit = 8'(cur_floor) + 8'(s_q.thresh[6:0]);
    end else begin
      ed_limit = 8'(s_q.thresh[6:0]);
    end
    ed_flag = 8'(strength) > ed_limit;
    fsel = s_q.func[cca_pkg::FUNC_LSB +: 2];
    unique case (fsel)
      cca_pkg::FN_ED_ONLY: busy_raw = ed_flag;
      cca_pkg::FN_SENSE: busy_raw = s_q.sense | s_q.quality;
      cca_pkg::FN_ED_AND: busy_raw = ed_flag & (s_q.sense | s_q.quality);
      cca_pkg::FN_ED_OR: busy_raw = ed_flag | s_q.sense | s_q.quality;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Noise floor sample store, kept across receive enable drops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_wp_q <= 8'h00;
    end else if (!psk_present && receive_path_enable) begin
      floor_mem[mem_wp_q] <= strength;
      mem_wp_q <= mem_wp_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [6:0] diff;
    logic eval;
    logic wr_fire;
    diff = 7'h00;
    eval = 1'b0;
    wr_fire = 1'b0;
    s_d = s_q;
    // Bus: write needs both address and data, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      wr_fire = 1'b1;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'h0;
      unique case (s_q.aw_addr)
        cca_pkg::OFS_FUNC: s_d.func = s_q.w_data;
        cca_pkg::OFS_POL: s_d.pol = s_q.w_data;
        cca_pkg::OFS_SAMPLE: s_d.sample = s_q.w_data;
        cca_pkg::OFS_THRESH: s_d.thresh = s_q.w_data;
        cca_pkg::OFS_SQUELCH: s_d.squelch = s_q.w_data;
        cca_pkg::OFS_QUAL: s_d.qual = s_q.w_data;
        default: s_d.bresp = 2'h2;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = 2'h0;
      unique case (s_axi_araddr[7:0])
        cca_pkg::OFS_FUNC: s_d.rdata = s_q.func;
        cca_pkg::OFS_POL: s_d.rdata = s_q.pol;
        cca_pkg::OFS_SAMPLE: s_d.rdata = s_q.sample;
        cca_pkg::OFS_THRESH: s_d.rdata = s_q.thresh;
        cca_pkg::OFS_SQUELCH: s_d.rdata = s_q.squelch;
        cca_pkg::OFS_QUAL: s_d.rdata = s_q.qual;
        cca_pkg::OFS_STATUS: s_d.rdata = {22'h0, s_q.gain, ed_flag, s_q.sense, s_q.quality};
        cca_pkg::OFS_FLOOR: s_d.rdata = {15'h0, s_q.floor_valid, 1'b0, s_q.floor1, 1'b0, s_q.floor0};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = 2'h2;
        end
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (wr_fire && s_q.w_strb != 4'hF && s_q.aw_addr != 8'hFF) begin
      s_d.bresp = s_d.bresp; // Partial strobes still write the full word
    end

    if (!receive_path_enable) begin
      // Receive off: gain back to high, learned floors untouched
      s_d.gain = cca_pkg::GAIN_MAX;
      s_d.lna_on = 1'b1;
      s_d.locked = 1'b0;
      s_d.seen_unlock = 1'b0;
      s_d.sense = 1'b0;
      s_d.quality = 1'b0;
      s_d.sq_prev = 1'b0;
      s_d.dwell_cnt = 16'h0000;
      s_d.locked_dwell = 1'b0;
      s_d.phase = CCA_IDLE;
    end else begin
      // Gain loop
      if (!s_q.locked) begin
        if (sat_percent > 8'h40 && s_q.gain > 7'(cca_pkg::BIG_STEP)) begin
          s_d.gain = 7'(s_q.gain - 7'(cca_pkg::BIG_STEP));
        end else if (sat_percent != 8'h00 && s_q.gain != 7'h00) begin
          s_d.gain = 7'(s_q.gain - 7'(cca_pkg::SMALL_STEP));
        end else if (adc_level <= lock_window) begin
          s_d.locked = 1'b1;
          s_d.lock_level = adc_level;
          if (s_q.seen_unlock) begin
            s_d.phase = CCA_SEARCH;
          end
        end
      end else begin
        diff = adc_level > s_q.lock_level ? 7'(adc_level - s_q.lock_level)
                                          : 7'(s_q.lock_level - adc_level);
        if (diff > drift_limit) begin
          s_d.locked = 1'b0;
          s_d.seen_unlock = 1'b1;
          s_d.sense = 1'b1;
          s_d.locked_dwell = 1'b0;
        end
      end
      // LNA switch with hysteresis
      if (s_q.lna_on && rf_power > cca_pkg::LNA_ON_LVL) begin
        s_d.lna_on = 1'b0;
      end else if (!s_q.lna_on && rf_power < cca_pkg::LNA_OFF_LVL) begin
        s_d.lna_on = 1'b1;
      end
      // Dwell timer and quality evaluation
      if (s_q.dwell_cnt == 16'(cca_pkg::DWELL_CYC - 1)) begin
        s_d.dwell_cnt = 16'h0000;
        s_d.locked_dwell = s_d.locked;
      end else begin
        s_d.dwell_cnt = 16'(s_q.dwell_cnt + 16'h0001);
      end
      // No evaluation in an unlock cycle, so a fresh sense set wins over the clear
      eval = s_q.dwell_cnt == 16'(cca_pkg::SQ_EVAL_CYC) && s_q.locked_dwell && s_q.locked
             && s_d.locked;
      if (eval) begin
        s_d.quality = pn_detect && (peak_sidelobe > s_q.qual[7:0]);
        s_d.sq_prev = s_d.quality;
        if (s_q.sense) begin
          s_d.sense = s_d.quality ? s_q.sense : 1'b0;
          if (s_d.quality) begin
            s_d.phase = CCA_TRACK;
          end
        end else if (s_d.quality && s_q.sq_prev) begin
          s_d.phase = CCA_TRACK;
        end
      end
      if (s_q.phase == CCA_SEARCH && pn_detect && s_q.locked) begin
        if (!(s_q.squelch[cca_pkg::SQUELCH_BIT] && !ed_flag)) begin
          s_d.phase = CCA_ACQ;
        end
      end
      if (s_q.phase == CCA_TRACK && s_q.sense && s_q.quality) begin
        s_d.sense = 1'b1; // Busy held while tracking
      end
    end

    // Noise floor learning, only while receiving with no PSK present;
    // the forced gain of a disabled receiver would spoil the floors
    if (!psk_present && receive_path_enable) begin
      if (strength < s_q.run_min) begin
        s_d.run_min = strength;
      end
      s_d.fill_cnt = 9'(s_q.fill_cnt + 9'h001);
      if (s_q.fill_cnt == 9'(DEPTH - 1)) begin
        s_d.fill_cnt = 9'h000;
        s_d.run_min = 7'h7F;
        if (antenna_sel) begin
          s_d.floor1 = strength < s_q.run_min ? strength : s_q.run_min;
        end else begin
          s_d.floor0 = strength < s_q.run_min ? strength : s_q.run_min;
        end
      end
    end
    // Early floor from running minimum
    if (!s_q.floor_valid && receive_path_enable) begin
      s_d.init_cnt = 16'(s_q.init_cnt + 16'h0001);
      if (s_q.init_cnt == 16'(FLOOR_INIT - 1)) begin
        s_d.floor_valid = 1'b1;
        s_d.floor0 = s_q.run_min;
        s_d.floor1 = s_q.run_min;
      end
    end

    // Sampled mode: busy moves only on symbol ticks
    if (s_q.sym_cnt == 8'(cca_pkg::SYMBOL_CYC - 1)) begin
      s_d.sym_cnt = 8'h00;
      s_d.busy_smp = busy_raw;
    end else begin
      s_d.sym_cnt = 8'(s_q.sym_cnt + 8'h01);
    end
    s_d.busy_out = (s_q.sample[cca_pkg::SAMPLE_BIT] ? s_d.busy_smp : busy_raw)
                   ^ s_q.pol[cca_pkg::POL_BIT];
  end

  ////////////////////////////////////////////////////////////////////
  // State register; floors survive enable drops, cleared only on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.func <= cca_pkg::RST_FUNC;
      s_q.thresh <= cca_pkg::RST_THRESH;
      s_q.qual <= cca_pkg::RST_QUAL;
      s_q.gain <= cca_pkg::GAIN_MAX;
      s_q.lna_on <= 1'b1;
      s_q.run_min <= 7'h7F;
      s_q.phase <= CCA_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  // No new write is taken while a response waits
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign channel_busy = s_q.busy_out;
  assign rx_gain = s_q.gain;
  assign lna_enable = s_q.lna_on;
  assign acquire = s_q.phase == CCA_ACQ;
  assign tracking = s_q.phase == CCA_TRACK;
  assign pn_search = s_q.phase == CCA_SEARCH;

endmodule

// ===== cca_mac.sv
`timescale 1ns/1ps
// MAC model: reads the busy pin and decides when it may send
module cca_mac #(
  parameter int WAIT_MAX = 20000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic receive_path_enable,
  input wire logic demod_data_ready,
  input wire logic channel_busy,
  input wire logic busy_low,
  output logic mac_clear,
  output logic mac_gave_up
);
  int wait_q;
  ////////////////////////
  // Busy is not trusted outside a receive or once data flows
  always_ff @(posedge aclk) begin
    if (!aresetn || !receive_path_enable || demod_data_ready) begin
      mac_clear <= 1'b0;
      wait_q <= 0;
    end else begin
      mac_clear <= channel_busy == busy_low;
      wait_q <= mac_clear ? 0 : wait_q + 1;
    end
  end
  // Long busy spell: send anyway rather than stall
  assign mac_gave_up = wait_q >= WAIT_MAX;
endmodule

// ===== cca_pkg.sv
package cca_pkg;
  // Busy-function selections (two-bit select field)
  localparam logic [1:0] FN_ED_ONLY = 2'h0;
  localparam logic [1:0] FN_SENSE = 2'h1;
  localparam logic [1:0] FN_ED_AND = 2'h2;
  localparam logic [1:0] FN_ED_OR = 2'h3;

  // Register byte offsets
  localparam logic [7:0] OFS_FUNC = 8'h24;
  localparam logic [7:0] OFS_POL = 8'h04;
  localparam logic [7:0] OFS_SAMPLE = 8'h2C;
  localparam logic [7:0] OFS_THRESH = 8'h98;
  localparam logic [7:0] OFS_SQUELCH = 8'hC0;
  localparam logic [7:0] OFS_QUAL = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h44;
  localparam logic [7:0] OFS_FLOOR = 8'h48;

  // Field positions
  localparam int FUNC_LSB = 5;
  localparam int POL_BIT = 2;
  localparam int SAMPLE_BIT = 3;
  localparam int THR_MODE_BIT = 8;
  localparam int SQUELCH_BIT = 0;

  // Reset values
  localparam logic [31:0] RST_FUNC = 32'h0000_0000;
  localparam logic [31:0] RST_THRESH = 32'h0000_0020;
  localparam logic [31:0] RST_QUAL = 32'h0000_0010;

  // Timing, in ns, and cycle counts at 100 MHz
  localparam int CLK_NS = 10;
  localparam int DWELL_NS = 10000;
  localparam int SQ_EARLY_NS = 8000;
  localparam int SQ_LATE_NS = 9000;
  localparam int FLOOR_INIT_NS = 50000;
  localparam int SYMBOL_NS = 1000;
  localparam int DWELL_CYC = DWELL_NS / CLK_NS;
  localparam int SQ_EVAL_CYC = (SQ_EARLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SQ_LATE_CYC = SQ_LATE_NS / CLK_NS;
  localparam int FLOOR_INIT_CYC = FLOOR_INIT_NS / CLK_NS;
  localparam int SYMBOL_CYC = SYMBOL_NS / CLK_NS;

  // Gain loop constants and the noise floor window depth
  localparam int LNA_DB = 30;
  localparam logic [6:0] GAIN_MAX = 7'h7F;
  localparam logic [6:0] LNA_ON_LVL = 7'h70;
  localparam logic [6:0] LNA_OFF_LVL = 7'h60;
  localparam int BIG_STEP = 8;
  localparam int SMALL_STEP = 1;
  localparam int FLOOR_DEPTH = 256;
endpackage

// ===== cca_props.sv
`timescale 1ns/1ps
// Watches bus handshakes and the gain path at the core's ports
module cca_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] rf_power,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [6:0] rx_gain,
  input wire logic lna_enable,
  input wire logic acquire,
  input wire logic tracking,
  input wire logic pn_search
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////
  // Power inside the band must not flip the LNA, else it would chatter
  logic rf_mid;
  assign rf_mid = rf_power > cca_pkg::LNA_OFF_LVL && rf_power < cca_pkg::LNA_ON_LVL;

  AST_GAIN_START:
    assert property (!$past(aresetn) |-> rx_gain == 7'h7F && lna_enable)
    else $error("gain or lna not at start value");
  AST_LNA_HYST:
    assert property ($past(rf_mid) |-> $stable(lna_enable))
    else $error("lna switched inside hysteresis band");
  AST_B_AFTER_AW:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_B_BLOCKS:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_R_AFTER_AR:
    assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  AST_AR_REFUSE:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  AST_UNMAPPED_ZERO:
    assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  AST_ONE_PHASE:
    assert property ($onehot0({acquire, tracking, pn_search}))
    else $error("more than one receive phase");

  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_UNMAPPED: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  COV_LNA_OFF: cover property ($fell(lna_enable));
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, receive_path_enable, antenna_sel, pn_detect, psk_present;
  logic demod_data_ready, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, channel_busy, lna_enable, acquire, tracking, pn_search;
  logic mac_clear, mac_gave_up, pol_low;
  logic [6:0] adc_level, lock_window, drift_limit, rf_power, rx_gain;
  logic [7:0] sat_percent, peak_sidelobe;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrs, fn;
  int n_fail, tests_run, cyc;
  ////////////////////////
  // Short floor warm-up keeps the run brief
  cca_core #(.FLOOR_INIT(50)) u_dut (.*);
  cca_mac u_mac (.aclk, .aresetn, .receive_path_enable, .demod_data_ready,
    .channel_busy, .busy_low(pol_low), .mac_clear, .mac_gave_up);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Watchdog, well above the 10k or so cycles the sequence needs at most
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic note(string s);
    $display("test %s done", s);
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  // Late rready so the slave must hold its data a cycle
  task automatic rd(logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rrs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp);
    rd(a);
    check(what, rdv, exp);
  endtask
  task automatic wait_busy(string what, logic exp, int lim);
    int n;
    n = 0;
    while (channel_busy !== exp && n < lim) begin
      @(posedge aclk);
      n++;
    end
    check(what, channel_busy, exp);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    receive_path_enable = 1'b0;
    antenna_sel = 1'b0;
    adc_level = 7'h20;
    sat_percent = 8'h00;
    lock_window = 7'h40;
    drift_limit = 7'h08;
    rf_power = 7'h7F;
    pn_detect = 1'b0;
    peak_sidelobe = 8'h00;
    psk_present = 1'b0;
    demod_data_ready = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    pol_low = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then an unmapped place
    rd_chk("func", cca_pkg::OFS_FUNC, cca_pkg::RST_FUNC);
    rd_chk("thresh", cca_pkg::OFS_THRESH, cca_pkg::RST_THRESH);
    rd_chk("qual", cca_pkg::OFS_QUAL, cca_pkg::RST_QUAL);
    rd_chk("unmapped", 8'hF0, 32'h0);
    check("unmapped resp", rrs, 2'h2);
    wr(cca_pkg::OFS_THRESH, 32'h0000_0005);
    rd_chk("thresh back", cca_pkg::OFS_THRESH, 32'h0000_0005);
    note("registers");
    // LNA off, so strength and floor sit at 30
    wr(cca_pkg::OFS_POL, 32'h0);
    receive_path_enable <= 1'b1;
    repeat (2 * cca_pkg::DWELL_CYC + 100) @(posedge aclk);
    rd(cca_pkg::OFS_FLOOR);
    check("floor", {rdv[16], rdv[6:0]}, 8'h9E);
    for (int f = 0; f < 4; f++) begin
      fn = f[1:0];
      wr(cca_pkg::OFS_FUNC, {25'h0, fn, 5'h00});
      wait_busy("busy fn", fn == cca_pkg::FN_ED_ONLY || fn == cca_pkg::FN_ED_OR, 40);
    end
    rd(cca_pkg::OFS_STATUS);
    check("status", rdv[2:0], 3'b100);
    check("mac clear", mac_clear, 1'b0);
    wr(cca_pkg::OFS_POL, 32'h0000_0004);
    pol_low <= 1'b1;
    wait_busy("busy low", 1'b0, 40);
    wr(cca_pkg::OFS_POL, 32'h0);
    pol_low <= 1'b0;
    // 5 above a floor of 30 is out of reach
    wr(cca_pkg::OFS_FUNC, 32'h0);
    wr(cca_pkg::OFS_THRESH, 32'h0000_0105);
    wait_busy("busy rel", 1'b0, 40);
    receive_path_enable <= 1'b0;
    repeat (50) @(posedge aclk);
    rd(cca_pkg::OFS_FLOOR);
    check("floor kept", {rdv[16], rdv[6:0]}, 8'h9E);
    receive_path_enable <= 1'b1;
    note("energy");
    // Let strong power switch the LNA off first
    repeat (5) @(posedge aclk);
    // Power inside the band keeps whichever LNA state it had
    rf_power <= 7'h68;
    repeat (20) @(posedge aclk);
    check("lna held off", lna_enable, 1'b0);
    rf_power <= 7'h10;
    repeat (20) @(posedge aclk);
    check("lna on", lna_enable, 1'b1);
    rf_power <= 7'h68;
    repeat (20) @(posedge aclk);
    check("lna held on", lna_enable, 1'b1);
    note("lna");
    // Unlock raises sense at once; a failed evaluation clears it
    wr(cca_pkg::OFS_FUNC, 32'h0000_0020);
    adc_level <= 7'h60;
    wait_busy("sense set", 1'b1, 20);
    adc_level <= 7'h20;
    wait_busy("sense clear", 1'b0, 2200);
    pn_detect <= 1'b1;
    peak_sidelobe <= 8'h08;
    repeat (2200) @(posedge aclk);
    check("weak peak", channel_busy, 1'b0);
    check("acquire", acquire, 1'b1);
    peak_sidelobe <= 8'h20;
    wait_busy("quality", 1'b1, 2200);
    repeat (cca_pkg::DWELL_CYC + 100) @(posedge aclk);
    check("tracking", tracking, 1'b1);
    note("quality");
    end_of_test();
  end
endmodule

bind cca_core cca_props u_props (.*);
